//--- src/mtx_pkg.sv
// Shared constants and types for the transmit nibble input block
package mtx_pkg;

	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int NIB_W = 4;
	localparam int FIFO_DEPTH = 2;

	// ----------------------------------------------------------------
	// Timing: reference and transmit clock rates
	// ----------------------------------------------------------------
	localparam int REF_FREQ_KHZ = 25000;
	localparam int TX_NIBBLE_CLOCK_100_KHZ = 25000;
	localparam int TX_NIBBLE_CLOCK_10_KHZ = 2500;
	localparam int REF_DIV_10_INT = REF_FREQ_KHZ / TX_NIBBLE_CLOCK_10_KHZ;
	localparam logic [3:0] REF_DIV_10 = 4'(REF_DIV_10_INT);
	localparam logic [3:0] REF_HIGH_10 = 4'(REF_DIV_10_INT / 2);
	localparam logic [3:0] REF_CNT_ZERO = 4'h0;
	localparam logic [3:0] REF_CNT_ONE = 4'h1;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
	localparam logic SPEED_RESET = 1'b0;
	localparam logic XOVER_RESET = 1'b1;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic last;
		logic [NIB_W-1:0] nibble;
	} mtx_word_t;

	typedef struct packed {
		logic ref_clock;
		logic frame_valid;
		logic [NIB_W-1:0] nibble;
		logic speed_100;
		logic xover;
	} mtx_pins_t;

	localparam mtx_word_t WORD_RESET = '{last: 1'b0, nibble: NIB_RESET};
	localparam mtx_pins_t PINS_RESET = '{ref_clock: 1'b0,
		frame_valid: 1'b0, nibble: NIB_RESET, speed_100: SPEED_RESET,
		xover: XOVER_RESET};

	typedef enum logic [1:0] {
		MTX_IDLE = 2'b01,
		MTX_FRAME = 2'b10
	} mtx_state_t;

endpackage : mtx_pkg

//--- src/mtx_fifo2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module mtx_fifo2
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire mtx_pkg::mtx_word_t in_word,
	output logic out_valid,
	input wire logic out_ready,
	output mtx_pkg::mtx_word_t out_word
);
	import mtx_pkg::*;

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	mtx_word_t mem [FIFO_DEPTH];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;

	wire logic do_push;
	wire logic do_pop;
	wire logic [1:0] next_count;

	assign in_ready = (count != 2'(FIFO_DEPTH));
	assign out_valid = (count != 2'h0);
	assign out_word = mem[rd_ptr];
	assign do_push = in_valid & in_ready;
	assign do_pop = out_valid & out_ready;
	assign next_count = count + 2'(do_push) - 2'(do_pop);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
			mem[0] <= WORD_RESET;
			mem[1] <= WORD_RESET;
		end
		else if (ce)
		begin
			if (do_push)
			begin
				mem[wr_ptr] <= in_word;
				wr_ptr <= ~wr_ptr;
			end
			if (do_pop)
				rd_ptr <= ~rd_ptr;
			count <= next_count;
		end
	end

endmodule : mtx_fifo2

//--- src/mtx_tx.sv
// Transmit nibble input of the media independent interface
//
// Operation
// RQ1: Nibble is four bits, bit 0 least significant, bit 3 most.
// RQ2: While frame valid is high, capture nibble at every transmit clock rise.
// RQ3: Frame valid tells when data is offered; capture starts on it.
// RQ4: Every nibble captured during frame valid goes out to the media; a nibble pushed while the buffer is full is dropped and raises tx_overrun.
// RQ5: After frame valid drops, no further nibbles go to the media.
// RQ6: Speed output high at 100 Mb/s, low at 10 Mb/s.
// RQ7: Reset input is active low; low holds reset, high releases.
// RQ8: All timing derives from the 25 MHz reference input.
// RQ9: Crossover enable input; floating reads high through a pull-up.
// RQ10: Transmit clock is 2.5 MHz at 10 Mb/s, 25 MHz at 100 Mb/s.
// RQ11: MAC holds frame valid over the frame, new nibble every rise.
`timescale 1ns/1ps
module mtx_tx
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic ref_clock,
	input wire logic speed_100_select,
	input wire logic crossover_auto_enable,
	input wire logic tx_frame_valid,
	input wire logic [mtx_pkg::NIB_W-1:0] tx_nibble,
	output logic tx_nibble_clock,
	output logic speed_100_indicate,
	output logic crossover_auto_active,
	output logic media_valid,
	input wire logic media_ready,
	output mtx_pkg::mtx_word_t media_word,
	output logic tx_overrun
);
	import mtx_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// A bit takes the new level only once the two late stages agree
	function automatic mtx_pins_t settle(mtx_pins_t s2, mtx_pins_t s3,
		mtx_pins_t held);
		mtx_pins_t differ;
		differ = s2 ^ s3;
		settle = (s3 & ~differ) | (held & differ);
	endfunction : settle

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	// Stage 1 is read only by stage 2, to keep metastability contained
	mtx_pins_t pin_raw;
	mtx_pins_t sync1;
	mtx_pins_t sync2;
	mtx_pins_t sync3;
	mtx_pins_t pins;
	wire mtx_pins_t next_pins;

	assign pin_raw.ref_clock = ref_clock;
	assign pin_raw.frame_valid = tx_frame_valid;
	assign pin_raw.nibble = tx_nibble; // RQ1
	assign pin_raw.speed_100 = speed_100_select;
	assign pin_raw.xover = crossover_auto_enable;
	assign next_pins = settle(sync2, sync3, pins);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n) // RQ7
		begin
			sync1 <= PINS_RESET;
			sync2 <= PINS_RESET;
			sync3 <= PINS_RESET;
			pins <= PINS_RESET;
		end
		else if (ce)
		begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			pins <= next_pins;
		end
	end

	// ----------------------------------------------------------------
	// Configuration outputs
	// ----------------------------------------------------------------
	// Speed only changes while idle, including the cycle that takes a frame's first nibble
	mtx_state_t state;
	wire logic speed_may_change;

	assign speed_may_change = (state == MTX_IDLE);

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			speed_100_indicate <= SPEED_RESET;
			crossover_auto_active <= XOVER_RESET;
		end
		else if (ce)
		begin
			if (speed_may_change)
				speed_100_indicate <= pins.speed_100; // RQ6
			crossover_auto_active <= pins.xover; // RQ9
		end
	end

	// ----------------------------------------------------------------
	// Transmit clock generation from the reference
	// ----------------------------------------------------------------
	logic ref_prev;
	logic [3:0] ref_count;
	wire logic ref_rise;
	wire logic ref_wrap;
	wire logic [3:0] next_ref_count;
	wire logic next_tx_nibble_clock_10;
	wire logic next_tx_nibble_clock;
	wire logic tx_nibble_clock_rise;

	assign ref_rise = pins.ref_clock & ~ref_prev; // RQ8
	assign ref_wrap = (ref_count == REF_DIV_10 - REF_CNT_ONE);
	assign next_ref_count = ref_wrap ? REF_CNT_ZERO
		: ref_count + REF_CNT_ONE;
	assign next_tx_nibble_clock_10 = (ref_count < REF_HIGH_10);
	// One reference period per nibble at 100, ten at 10
	assign next_tx_nibble_clock = speed_100_indicate ? pins.ref_clock
		: next_tx_nibble_clock_10; // RQ10
	assign tx_nibble_clock_rise = next_tx_nibble_clock & ~tx_nibble_clock;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ref_prev <= 1'b0;
			ref_count <= REF_CNT_ZERO;
			tx_nibble_clock <= 1'b0;
		end
		else if (ce)
		begin
			ref_prev <= pins.ref_clock;
			if (ref_rise)
				ref_count <= next_ref_count; // RQ10
			tx_nibble_clock <= next_tx_nibble_clock;
		end
	end

	// ----------------------------------------------------------------
	// Frame capture
	// ----------------------------------------------------------------
	// A nibble is held one beat so its last mark is known on push
	logic held_valid;
	logic [NIB_W-1:0] held_nibble;
	mtx_state_t next_state;
	wire logic offer;
	wire logic take;
	wire logic close;
	wire logic push;
	wire mtx_word_t push_word;
	wire logic buf_in_ready;

	// The MAC keeps the strobe high for the whole frame
	assign offer = tx_nibble_clock_rise & pins.frame_valid; // RQ3 RQ11
	assign take = offer; // RQ2
	assign close = tx_nibble_clock_rise & ~pins.frame_valid & held_valid; // RQ5
	assign push = (take | close) & held_valid; // RQ4
	assign push_word.last = close;
	assign push_word.nibble = held_nibble;

	always_comb
	begin
		next_state = state;
		unique case (state)
			MTX_IDLE:
				if (take)
					next_state = MTX_FRAME;
			MTX_FRAME:
				if (close)
					next_state = MTX_IDLE;
			default:
				next_state = MTX_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= MTX_IDLE;
			held_valid <= 1'b0;
			held_nibble <= NIB_RESET;
			tx_overrun <= 1'b0;
		end
		else if (ce)
		begin
			state <= next_state;
			if (take)
			begin
				held_valid <= 1'b1;
				held_nibble <= pins.nibble; // RQ2
			end
			else if (close)
				held_valid <= 1'b0; // RQ5
			// A stalled media side cannot stop the MAC; loss is flagged
			tx_overrun <= push & ~buf_in_ready;
		end
	end

	// ----------------------------------------------------------------
	// Buffer toward the media
	// ----------------------------------------------------------------
	wire logic buf_out_valid;
	wire logic buf_out_ready;
	wire mtx_word_t buf_out_word;
	wire logic out_load;

	mtx_fifo2 u_buf
	(
		.clk(core_clk),
		.rst_n(rst_n),
		.ce(ce),
		.in_valid(push),
		.in_ready(buf_in_ready),
		.in_word(push_word),
		.out_valid(buf_out_valid),
		.out_ready(buf_out_ready),
		.out_word(buf_out_word)
	);

	assign buf_out_ready = ~media_valid | media_ready;
	assign out_load = buf_out_valid & buf_out_ready;

	// ----------------------------------------------------------------
	// Media output register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			media_valid <= 1'b0;
			media_word <= WORD_RESET;
		end
		else if (ce)
		begin
			if (buf_out_ready)
				media_valid <= buf_out_valid; // RQ4
			if (out_load)
				media_word <= buf_out_word;
		end
	end

endmodule : mtx_tx

//--- test/mtx_tx_monitor.sv
// Port checker for the transmit nibble input
`timescale 1ns/1ps
module mtx_tx_monitor
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic speed_100_select,
	input wire logic crossover_auto_enable,
	input wire logic tx_frame_valid,
	input wire logic tx_nibble_clock,
	input wire logic speed_100_indicate,
	input wire logic crossover_auto_active,
	input wire logic media_valid,
	input wire logic media_ready,
	input wire mtx_pkg::mtx_word_t media_word,
	input wire logic tx_overrun
);
	import mtx_pkg::*;
	logic [7:0] hi_cnt;
	logic clean, prev_clk, prev_spd, armed, steady;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	// A high phase cut by a speed change or by reset is not timed
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hi_cnt <= 8'h00;
			clean <= 1'b0;
			prev_clk <= 1'b0;
			prev_spd <= 1'b0;
			armed <= 1'b0;
			steady <= 1'b0;
		end
		else
		begin
			hi_cnt <= tx_nibble_clock ? hi_cnt + 8'h01 : 8'h00;
			prev_clk <= tx_nibble_clock;
			prev_spd <= speed_100_indicate;
			steady <= (speed_100_indicate == prev_spd);
			// Only a rise after a fall at one steady speed opens a full phase
			if (speed_100_indicate != prev_spd || !steady)
			begin
				armed <= 1'b0;
				clean <= 1'b0;
			end
			else if (!tx_nibble_clock && prev_clk)
				armed <= 1'b1;
			else if (tx_nibble_clock && !prev_clk)
				clean <= armed;
		end
	end
	sequence stalled;
		media_valid && !media_ready;
	endsequence
	sequence last_taken;
		media_valid && media_ready && media_word.last;
	endsequence
	reset_out_a: assert property ($rose(rst_n) |->
		!media_valid && !tx_overrun && crossover_auto_active)
		else $error("outputs not at reset values");
	stall_hold_a: assert property (stalled |=>
		media_valid && $stable(media_word)) else $error("word moved in stall");
	overrun_pulse_a: assert property (tx_overrun |=> !tx_overrun)
		else $error("overrun longer than a cycle");
	speed_high_a: assert property (
		(speed_100_select && !tx_frame_valid)[*8] |=> ##[0:8]
		speed_100_indicate) else $error("speed not high");
	speed_low_a: assert property (
		(!speed_100_select && !tx_frame_valid)[*8] |=> ##[0:8]
		!speed_100_indicate) else $error("speed not low");
	xover_follow_a: assert property (
		($stable(crossover_auto_enable))[*8] |->
		crossover_auto_active == crossover_auto_enable)
		else $error("crossover output wrong");
	clk100_high_a: assert property (
		$fell(tx_nibble_clock) && clean && speed_100_indicate |->
		hi_cnt inside {[8:12]}) else $error("fast clock high time");
	clk10_high_a: assert property (
		$fell(tx_nibble_clock) && clean && !speed_100_indicate |->
		hi_cnt inside {[98:102]}) else $error("slow clock high time");
	last_drain_a: assert property (last_taken |=> !media_valid[*4])
		else $error("word after frame end");
	first_word_a: assert property (
		$rose(tx_frame_valid) && speed_100_indicate |-> ##[1:80] media_valid)
		else $error("frame start not seen");
endmodule : mtx_tx_monitor
bind mtx_tx mtx_tx_monitor mon (.core_clk, .rst_n, .speed_100_select,
	.crossover_auto_enable, .tx_frame_valid, .tx_nibble_clock,
	.speed_100_indicate, .crossover_auto_active, .media_valid,
	.media_ready, .media_word, .tx_overrun);

//--- test/mtx_mac_model.sv
// Behavioural MAC driving the transmit nibble pins
`timescale 1ns/1ps
module mtx_mac_model
(
	input wire logic core_clk,
	input wire logic tx_nibble_clock,
	input wire logic go,
	input wire logic [7:0] len,
	input wire logic [3:0] base,
	output logic tx_frame_valid = 1'b0,
	output logic [3:0] tx_nibble = 4'h0,
	output logic busy = 1'b0
);
	logic prev_clk = 1'b0;
	logic [7:0] sent = 8'h00;
	// Pins move on the falling edge right after a clock rise is seen
	always @(negedge core_clk)
	begin
		prev_clk <= tx_nibble_clock;
		if (go)
			busy <= 1'b1;
		// Idle lines toggle so stale data never passes for a nibble
		if (!tx_frame_valid)
			tx_nibble <= ~tx_nibble;
		if (busy && tx_nibble_clock && !prev_clk)
		begin
			tx_frame_valid <= sent != len;
			tx_nibble <= base + sent[3:0];
			sent <= sent == len ? 8'h00 : sent + 8'h01;
			busy <= sent != len;
		end
	end
endmodule : mtx_mac_model

//--- test/tb.sv
// Self-checking bench for the transmit nibble input
`timescale 1ns/1ps
module tb;
	import mtx_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, ref_clock = 1'b0, go = 1'b0;
	logic speed_100_select = 1'b0, media_ready = 1'b1;
	logic crossover_auto_enable = 1'b1;
	logic busy, tx_frame_valid, tx_nibble_clock, tx_overrun;
	logic speed_100_indicate, crossover_auto_active, media_valid;
	logic [7:0] len = 8'h00;
	logic [NIB_W-1:0] base = 4'h0, tx_nibble;
	mtx_word_t media_word;
	mtx_word_t got[$];
	int mismatches = 0, check_count = 0, ovr = 0;
	initial forever #4 core_clk = ~core_clk;
	initial #13 forever #80 ref_clock = ~ref_clock;
	mtx_tx dut (.core_clk, .rst_n, .ce(1'b1), .ref_clock, .speed_100_select,
		.crossover_auto_enable, .tx_frame_valid, .tx_nibble, .tx_nibble_clock,
		.speed_100_indicate, .crossover_auto_active, .media_valid,
		.media_ready, .media_word, .tx_overrun);
	mtx_mac_model mac (.core_clk, .tx_nibble_clock, .go, .len, .base,
		.tx_frame_valid, .tx_nibble, .busy);
	always @(posedge core_clk)
	begin
		if (media_valid === 1'b1 && media_ready)
			got.push_back(media_word);
		if (tx_overrun === 1'b1)
			ovr++;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : results
	// Stalled runs keep only the buffer's two entries and the media register, so later nibbles drop
	task automatic run_frame(input logic spd, input logic [7:0] n,
		input logic [3:0] b, input logic stall);
		int k;
		speed_100_select <= spd;
		repeat (30) @(negedge core_clk);
		check(8'(speed_100_indicate), 8'(spd));
		got.delete();
		ovr = 0;
		media_ready <= !stall;
		len <= n;
		base <= b;
		go <= 1'b1;
		@(negedge core_clk);
		go <= 1'b0;
		@(negedge core_clk);
		for (k = 0; k < 30000 && busy; k++)
			@(negedge core_clk);
		check(8'(busy), 8'h00);
		repeat (250) @(negedge core_clk);
		media_ready <= 1'b1;
		repeat (250) @(negedge core_clk);
		if (stall)
		begin
			check(8'(got.size()), 8'h03);
			check(8'(ovr > 0), 8'h01);
		end
		else
			check(8'(got.size()), n);
		foreach (got[i])
			check(8'(got[i]), {3'h0, !stall && i == n - 1, b + 4'(i)});
	endtask : run_frame
	initial
	begin
		repeat (3) @(negedge core_clk);
		rst_n <= 1'b1;
		@(negedge core_clk);
		check(8'({media_valid, tx_overrun, speed_100_indicate}), 8'h00);
		check(8'(crossover_auto_active), 8'h01);
		crossover_auto_enable <= 1'b0;
		repeat (12) @(negedge core_clk);
		check(8'(crossover_auto_active), 8'h00);
		// Pin driven high again: the output follows it back high
		crossover_auto_enable <= 1'b1;
		repeat (12) @(negedge core_clk);
		check(8'(crossover_auto_active), 8'h01);
		run_frame(1'b1, 8'h06, 4'hA, 1'b0);
		run_frame(1'b1, 8'h01, 4'h5, 1'b0);
		run_frame(1'b0, 8'h03, 4'h3, 1'b0);
		run_frame(1'b1, 8'h0A, 4'h0, 1'b1);
		results();
	end
	initial
	begin
		#400_000;
		mismatches++;
		results();
	end
endmodule : tb
